// ===== testbench/cdrb_rx_lane_tb.sv
// Self-checking testbench for the receive lane block
`timescale 1ns/100ps
`default_nettype none
module cdrb_rx_lane_tb;
    import cdrb_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic manualPortsEn = 1'b0;
    logic wide10 = 1'b0;
    cdrb_bond_t bondMode = CDRB_BOND_X1;
    cdrb_op_t opMode = CDRB_OP_TXRX;
    logic [1:0] pllSel = 2'h1;
    cdrb_lock_in_t [NUM_CH-1:0] lockIn = '0;
    cdrb_ser_t serBit;
    logic [9:0] nextWord = 10'h000;
    logic [9:0] sentWord;
    logic sentStb;
    logic [NUM_CH-1:0] freqLocked, refLockState, lowClkTick, pllSelOut;
    cdrb_word_t [NUM_CH-1:0] wordOut;
    logic [NUM_CH*PTR_W-1:0] fifoWrPtr;
    logic cfgError;
    logic watch = 1'b0;
    logic [9:0] expQ[$];
    int num_errors = 0;
    int n_tests = 0;
    // {manual ports on, lock inputs, expected data lock}
    logic [8:0] lockTab [10] = '{9'h019, 9'h000, 9'h019, 9'h058, 9'h030,
        9'h183, 9'h186, 9'h183, 9'h181, 9'h082};
    // {bond mode, operation mode, expected error}
    logic [4:0] cfgTab [4] = '{5'h0b, 5'h1d, 5'h02, 5'h10};
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    cdrb_rx_lane #(.NCH(NUM_CH)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .manualPortsEn(manualPortsEn), .wide10(wide10), .bondMode(bondMode),
        .opMode(opMode), .pllSel(pllSel), .lockIn(lockIn),
        .serIn({NUM_CH{serBit}}), .freqLocked(freqLocked),
        .refLockState(refLockState), .wordOut(wordOut),
        .lowClkTick(lowClkTick), .fifoWrPtr(fifoWrPtr),
        .pllSelOut(pllSelOut), .cfgError(cfgError));
    cdrb_ser_src src_u (.clk_sys(clk_sys), .rst_n(rst_n), .wide10(wide10),
        .nextWord(nextWord), .serOut(serBit), .sentWord(sentWord),
        .sentStb(sentStb));
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic w10);
        @(negedge clk_sys);
        rst_n <= 1'b0;
        wide10 <= w10;
        watch <= 1'b0;
        repeat (3) @(negedge clk_sys);
        expQ.delete();
        rst_n <= 1'b1;
        watch <= 1'b1;
    endtask
    always @(negedge clk_sys) begin
        nextWord <= 10'($urandom);
    end
    always @(posedge clk_sys) begin
        if (watch && rst_n && sentStb) begin
            expQ.push_back(wide10 ? sentWord : {2'h0, sentWord[7:0]});
        end
    end
    always @(negedge clk_sys) begin
        logic [9:0] e;
        e = 10'h000;
        if (watch && wordOut[0].valid === 1'b1) begin
            if (expQ.size() == 0) begin
                check("unexpected word", 32'h1, 32'h0);
            end else begin
                e = expQ.pop_front();
                for (int c = 0; c < NUM_CH; c++) begin
                    check("word", {22'h0, wordOut[c].data}, {22'h0, e});
                end
            end
        end
        if (watch) begin
            check("tick", {28'h0, lowClkTick}, {28'h0, {NUM_CH{wordOut[0].valid}}});
        end
    end
    initial begin
        #1000000;
        num_errors++;
        conclude();
    end
    initial begin
        void'($urandom(48676));
        do_reset(1'b0);
        check("reset lock", {30'h0, freqLocked[0], refLockState[0]}, 32'h1);
        for (int i = 0; i < 10; i++) begin
            manualPortsEn <= lockTab[i][8];
            lockIn <= {NUM_CH{lockTab[i][7:1]}};
            repeat (3) @(negedge clk_sys);
            check("lock", {30'h0, freqLocked[0], refLockState[0]}, {30'h0, lockTab[i][0], ~lockTab[i][0]});
        end
        $display("Lock and 8-bit word test done");
        watch <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            bondMode <= cdrb_bond_t'(cfgTab[i][4:3]);
            opMode <= cdrb_op_t'(cfgTab[i][2:1]);
            repeat (3) @(negedge clk_sys);
            check("config error", {31'h0, cfgError}, {31'h0, cfgTab[i][0]});
        end
        $display("Configuration test done");
        bondMode <= CDRB_BOND_X4;
        opMode <= CDRB_OP_TXRX;
        do_reset(1'b0);
        repeat (22) @(negedge clk_sys);
        check("bonded pll", {28'h0, pllSelOut}, 32'hf);
        check("bonded ptr", {20'h0, fifoWrPtr}, 32'hb6d);
        $display("Bonded test done");
        bondMode <= CDRB_BOND_X1;
        do_reset(1'b1);
        repeat (60) @(negedge clk_sys);
        check("words drained", {31'h0, expQ.size() <= 2}, 32'h1);
        check("own pll", {28'h0, pllSelOut}, 32'h5);
        check("own ptr", {20'h0, fifoWrPtr}, 32'h924);
        $display("10-bit word test done");
        conclude();
    end
endmodule // cdrb_rx_lane_tb
`default_nettype wire

// ===== testbench/cdrb_ser_src.sv
// Upstream serial transmitter model feeding the receive lanes
`timescale 1ns/100ps
`default_nettype none
module cdrb_ser_src (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wide10,
    input wire logic [9:0] nextWord,
    output cdrb_pkg::cdrb_ser_t serOut,
    output logic [9:0] sentWord,
    output logic sentStb
);
    import cdrb_pkg::*;
    logic [2:0] pos_q;
    logic [9:0] cur;
    logic start;
    logic [2:0] idx;
    // Streams words back to back, aligned to reset release
    assign start = !rst_n || pos_q == (wide10 ? 3'h4 : 3'h3);
    assign idx = start ? 3'h0 : pos_q + 3'h1;
    assign cur = start ? nextWord : sentWord;
    initial begin
        pos_q = 3'h0;
        sentWord = 10'h000;
        sentStb = 1'b0;
        serOut = '0;
    end
    always @(negedge clk_sys) begin
        pos_q <= idx;
        sentWord <= cur;
        sentStb <= start;
        // Lower bit index goes first, two bits per clock
        serOut <= '{bitRise: cur[{idx, 1'b0}], bitFall: cur[{idx, 1'b1}]};
    end
endmodule // cdrb_ser_src
`default_nettype wire

// ===== verilog/cdrb_pkg.sv
// Package of constants and carrier types for the receive lock/deserialize block
package cdrb_pkg;
    localparam int NUM_CH = 4;
    localparam int WORD_MAX = 10;
    localparam int WIDTH_8 = 8;
    localparam int WIDTH_10 = 10;
    localparam int PTR_W = 3;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [PTR_W-1:0] PTR_RST = 3'h0;

    typedef enum logic [1:0] {
        CDRB_BOND_X1,
        CDRB_BOND_X2,
        CDRB_BOND_X4
    } cdrb_bond_t;

    typedef enum logic [1:0] {
        CDRB_OP_TX_ONLY,
        CDRB_OP_RX_ONLY,
        CDRB_OP_TXRX
    } cdrb_op_t;

    // Per-channel lock controller inputs
    typedef struct packed {
        logic manualEn;
        logic pipeMode;
        logic sigDetect;
        logic ppmInRange;
        logic phaseOk;
        logic lockToRef;
        logic lockToData;
    } cdrb_lock_in_t;

    // Per-channel deserializer input: two bits per recovered clock edge pair
    typedef struct packed {
        logic bitRise;
        logic bitFall;
    } cdrb_ser_t;

    typedef struct packed {
        logic [WORD_MAX-1:0] data;
        logic valid;
    } cdrb_word_t;
endpackage

// ===== verilog/cdrb_rx_lane.sv
// Receive lock controller, deserializer and channel bonding
`timescale 1ns/100ps
`default_nettype none

module cdrb_rx_lane #(
    parameter int NCH = cdrb_pkg::NUM_CH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic manualPortsEn,
    input wire logic wide10,
    input wire cdrb_pkg::cdrb_bond_t bondMode,
    input wire cdrb_pkg::cdrb_op_t opMode,
    input wire logic [1:0] pllSel,
    input wire cdrb_pkg::cdrb_lock_in_t [NCH-1:0] lockIn,
    input wire cdrb_pkg::cdrb_ser_t [NCH-1:0] serIn,
    output logic [NCH-1:0] freqLocked,
    output logic [NCH-1:0] refLockState,
    output cdrb_pkg::cdrb_word_t [NCH-1:0] wordOut,
    output logic [NCH-1:0] lowClkTick,
    output logic [NCH*cdrb_pkg::PTR_W-1:0] fifoWrPtr,
    output logic [NCH-1:0] pllSelOut,
    output logic cfgError
);
    import cdrb_pkg::*;

    // Configuration legality check
    wire rxOnly = (opMode == CDRB_OP_RX_ONLY);
    wire bonded = (bondMode != CDRB_BOND_X1);
    wire badBond = bonded && rxOnly;
    wire badX2 = (bondMode == CDRB_BOND_X2) && (NCH < 2);
    wire badX4 = (bondMode == CDRB_BOND_X4) && (NCH != 4);
    wire badMode = (bondMode == 2'h3) || (opMode == 2'h3);
    wire cfgBad = badBond || badX2 || badX4 || badMode;
    wire [3:0] wordLast = wide10 ? 4'(WIDTH_10 - 2) : 4'(WIDTH_8 - 2);

    logic cfgError_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfgError_q <= 1'b0;
        end else begin
            cfgError_q <= cfgBad;
        end
    end
    assign cfgError = cfgError_q;

    // Shared bonded pointer and word counter
    logic [3:0] bondCnt_q;
    logic [PTR_W-1:0] bondPtr_q;
    wire bondWrap = (bondCnt_q >= wordLast);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bondCnt_q <= CNT_RST;
            bondPtr_q <= PTR_RST;
        end else begin
            bondCnt_q <= bondWrap ? CNT_RST : bondCnt_q + 4'h2;
            bondPtr_q <= bondWrap ? bondPtr_q + 3'h1 : bondPtr_q;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : gLane
            // Channel is a bonded member for the selected mode
            wire member = (bondMode == CDRB_BOND_X4) ||
                ((bondMode == CDRB_BOND_X2) && (ch < 2));
            wire useBond = member && !cfgBad;

            // Lock controller
            wire manual = manualPortsEn && lockIn[ch].manualEn;
            wire sigLost = lockIn[ch].pipeMode && !lockIn[ch].sigDetect;
            wire autoToRef = sigLost || !lockIn[ch].ppmInRange;
            wire autoToData = lockIn[ch].ppmInRange &&
                lockIn[ch].phaseOk && !sigLost;
            wire manRef = lockIn[ch].lockToRef;
            wire manData = lockIn[ch].lockToData && !manRef;
            logic inRef_q;
            logic inRef_d;
            always_comb begin
                inRef_d = inRef_q;
                if (manual) begin
                    if (manRef) begin
                        inRef_d = 1'b1;
                    end else if (manData) begin
                        inRef_d = 1'b0;
                    end
                end else if (!inRef_q && autoToRef) begin
                    inRef_d = 1'b1;
                end else if (inRef_q && autoToData) begin
                    inRef_d = 1'b0;
                end
            end
            logic locked_q;
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    inRef_q <= 1'b1;
                    locked_q <= 1'b0;
                end else begin
                    inRef_q <= inRef_d;
                    locked_q <= !inRef_d;
                end
            end
            assign freqLocked[ch] = locked_q;
            assign refLockState[ch] = inRef_q;

            // Deserializer: two bits per cycle, LSB first
            logic [WORD_MAX-1:0] shift_q;
            logic [3:0] cnt_q;
            logic [PTR_W-1:0] ptr_q;
            logic [WORD_MAX-1:0] word_q;
            logic valid_q;
            logic tick_q;
            logic pll_q;
            wire ownWrap = (cnt_q >= wordLast);
            wire wrap = useBond ? bondWrap : ownWrap;
            wire [3:0] pos = useBond ? bondCnt_q : cnt_q;
            logic [WORD_MAX-1:0] shift_d;
            always_comb begin
                shift_d = shift_q;
                shift_d[pos] = serIn[ch].bitRise;
                shift_d[pos+4'h1] = serIn[ch].bitFall;
                if (!wide10) begin
                    shift_d[WORD_MAX-1:WIDTH_8] = 2'h0;
                end
            end
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    shift_q <= '0;
                    cnt_q <= CNT_RST;
                    ptr_q <= PTR_RST;
                    word_q <= '0;
                    valid_q <= 1'b0;
                    tick_q <= 1'b0;
                    pll_q <= 1'b0;
                end else begin
                    shift_q <= shift_d;
                    cnt_q <= ownWrap ? CNT_RST : cnt_q + 4'h2;
                    ptr_q <= useBond ? bondPtr_q :
                        (ownWrap ? ptr_q + 3'h1 : ptr_q);
                    valid_q <= wrap;
                    word_q <= wrap ? shift_d : word_q;
                    tick_q <= wrap;
                    pll_q <= useBond ? pllSel[0] : pllSel[ch % 2];
                end
            end
            assign wordOut[ch].data = word_q;
            assign wordOut[ch].valid = valid_q;
            assign lowClkTick[ch] = tick_q;
            assign fifoWrPtr[ch*PTR_W +: PTR_W] = ptr_q;
            assign pllSelOut[ch] = pll_q;

            flag_tracks_state_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) locked_q == !inRef_q)
                else $error("lock flag disagrees with state");
            manual_ref_wins_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) manual && manRef |=> inRef_q)
                else $error("manual ref request ignored");
            manual_data_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) manual && manData |=> locked_q)
                else $error("manual data request ignored");
            auto_drop_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) !manual && !inRef_q &&
                !lockIn[ch].ppmInRange |=> inRef_q && !locked_q)
                else $error("ppm loss did not drop lock");
            pipe_sig_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) !manual && !inRef_q && sigLost
                |=> inRef_q)
                else $error("signal loss did not drop lock");
            auto_hold_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) !manual && inRef_q && !autoToData
                |=> inRef_q)
                else $error("left ref lock without detectors");
            bond_ptr_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) $stable(useBond) && useBond
                |=> ptr_q == $past(bondPtr_q))
                else $error("bonded pointer differs");
            word_lsb_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) !useBond && cnt_q == 4'h0 &&
                !ownWrap ##1 $stable(useBond) [*1] |->
                shift_q[0] == $past(serIn[ch].bitRise))
                else $error("first bit not in LSB");

            // Word boundary of an unbonded lane
            sequence word_end_s;
                !useBond && ownWrap;
            endsequence
            // Word boundary of a bonded lane
            sequence bond_end_s;
                useBond && bondWrap;
            endsequence

            valid_pulse_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) valid_q |=> !valid_q)
                else $error("word valid longer than one cycle");
            tick_valid_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) tick_q == valid_q)
                else $error("low-speed tick off word boundary");
            narrow_word_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) !wide10 ##1 valid_q |->
                word_q[WORD_MAX-1:WIDTH_8] == 2'h0)
                else $error("narrow word has upper bits set");
            msb_last_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) word_end_s |=>
                word_q[$past(cnt_q) + 4'h1] ==
                $past(serIn[ch].bitFall))
                else $error("last bit not in MSB");
            own_ptr_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) word_end_s |=>
                ptr_q == $past(ptr_q) + 3'h1)
                else $error("own pointer did not advance");
            own_ptr_hold_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) !useBond && !ownWrap |=>
                ptr_q == $past(ptr_q))
                else $error("own pointer moved mid word");
            bond_tick_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) bond_end_s |=> tick_q)
                else $error("bonded tick missing");
            pll_own_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) !useBond |=>
                pll_q == $past(pllSel[ch % 2]))
                else $error("unbonded lane took wrong PLL");
            pll_bond_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) useBond |=>
                pll_q == $past(pllSel[0]))
                else $error("bonded lane took wrong PLL");
            manual_hold_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) manual && !manRef &&
                !lockIn[ch].lockToData |=> $stable(inRef_q))
                else $error("manual state moved without request");
            auto_enter_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) !manual && inRef_q && autoToData
                |=> !inRef_q && locked_q)
                else $error("detectors did not enter data lock");
            auto_stay_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) !manual && !inRef_q && !autoToRef
                |=> !inRef_q)
                else $error("data lock dropped without cause");
            no_pipe_sig_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) !manual && !inRef_q &&
                !lockIn[ch].pipeMode && lockIn[ch].ppmInRange
                |=> !inRef_q)
                else $error("signal detect used outside PIPE");
            flag_rise_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) $rose(locked_q) |-> $fell(inRef_q))
                else $error("lock flag rose without data lock");
            auto_mode_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) !manualPortsEn && inRef_q &&
                autoToData |=> !inRef_q)
                else $error("auto mode not used without ports");
            x2_member_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) bondMode == CDRB_BOND_X2 |->
                member == (ch < 2))
                else $error("two-lane bond on wrong channel");
            x4_member_a: assert property (@(posedge clk_sys)
                disable iff (!rst_n) bondMode == CDRB_BOND_X4 |->
                member)
                else $error("four-lane bond missing a channel");
        end
    endgenerate

    cfg_mode3_a: assert property (@(posedge clk_sys)
        disable iff (!rst_n) badMode |=> cfgError_q)
        else $error("illegal mode not flagged");
    cfg_clean_a: assert property (@(posedge clk_sys)
        disable iff (!rst_n) !cfgBad |=> !cfgError_q)
        else $error("legal configuration flagged");
    bond_wrap_a: assert property (@(posedge clk_sys)
        disable iff (!rst_n) bondWrap |=> bondCnt_q == CNT_RST)
        else $error("shared counter did not restart");
    bond_step_a: assert property (@(posedge clk_sys)
        disable iff (!rst_n) !bondWrap |=>
        bondCnt_q == $past(bondCnt_q) + 4'h2)
        else $error("shared counter step wrong");
    bond_ptr_step_a: assert property (@(posedge clk_sys)
        disable iff (!rst_n) bondWrap |=>
        bondPtr_q == $past(bondPtr_q) + 3'h1)
        else $error("shared pointer did not advance");

    bond_rx_only_a: assert property (@(posedge clk_sys)
        disable iff (!rst_n) bonded && rxOnly |=> cfgError_q)
        else $error("receive-only bonding not flagged");
endmodule // cdrb_rx_lane

`default_nettype wire
